// File: bench/flash_device_model.sv
// Behavioural parallel flash device answering the host pins
`timescale 1ns/10ps
module flash_device_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MFG_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3  // Arbitrary value
)(
  input  wire flash_pins_s pins_in,
  output logic [7:0]       data_out,
  output logic             viol_out = 1'b0,
  output logic [7:0]       mode_out = CMD_SET_READ,
  output int               verify_count_out = 0
);
  // Small array; higher addresses alias
  logic [7:0]  mem [16] = '{default: ERASED_BYTE};
  logic [7:0]  last = 8'h00;
  logic [17:0] tmp_addr = '0;
  logic [17:0] lat_addr = '0;
  logic        busy = 1'b0;
  realtime     t_pulse = 0.0;
  realtime     t_write = 0.0;
  realtime     limit = 0.0;
  always @(negedge pins_in.write_n) begin
    tmp_addr = pins_in.addr;
    if (!pins_in.vpp_high || (busy && $realtime - t_pulse < limit)) viol_out = 1'b1;
  end
  always @(posedge pins_in.write_n) begin
    t_write = $realtime;
    if (!pins_in.chip_sel_n && pins_in.vpp_high) begin
      if (mode_out == CMD_PROGRAM && !busy) begin
        lat_addr = tmp_addr;
        mem[tmp_addr[3:0]] = mem[tmp_addr[3:0]] & pins_in.data_out;
        busy = 1'b1;
        limit = 10000.0;
        t_pulse = $realtime;
      end else begin
        busy = pins_in.data_out == CMD_ERASE && mode_out == CMD_ERASE;
        if (busy) begin
          mem = '{default: ERASED_BYTE};
          limit = 9500000.0;
          t_pulse = $realtime;
        end
        if (pins_in.data_out == CMD_ERASE_VERIFY) lat_addr = tmp_addr;
        if (pins_in.data_out == CMD_PROG_VERIFY) verify_count_out++;
        mode_out = (pins_in.data_out == CMD_RESET && mode_out == CMD_RESET) ?
          CMD_SET_READ : pins_in.data_out;
      end
    end
  end
  always @(negedge pins_in.out_gate_n) begin
    if (pins_in.data_oe || $realtime - t_write < 6000.0) viol_out = 1'b1;
  end
  always @* begin
    if (!pins_in.chip_sel_n && !pins_in.out_gate_n && pins_in.write_n) begin
      case (pins_in.vpp_high ? mode_out : CMD_SET_READ)
        CMD_SIGNATURE: data_out = pins_in.addr[0] ? DEV_ID : MFG_ID;
        CMD_PROG_VERIFY, CMD_ERASE_VERIFY: data_out = mem[lat_addr[3:0]];
        default: data_out = mem[pins_in.addr[3:0]];
      endcase
      last = data_out;
    end else begin
      data_out = ~last; // Released bus shows no stale byte
    end
  end
endmodule

// File: bench/flash_host_bench.sv
// Testbench for the flash host controller against a device model
`timescale 1ns/10ps
module flash_host_bench;
  import flash_host_pkg::*;
  typedef struct packed {
    host_op_e    op;
    logic [17:0] addr;
    logic [7:0]  data;
    logic        fail;
    logic [7:0]  exp;
  } row_s;
  localparam logic [7:0] MFG_ID = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV_ID = 8'hC3; // Arbitrary value
  localparam row_s ROWS [6] = '{
    '{OP_READ,      18'h00003, 8'h00, 1'b0, ERASED_BYTE},
    '{OP_SIGNATURE, 18'h00000, 8'h00, 1'b0, MFG_ID},
    '{OP_SIGNATURE, 18'h00001, 8'h00, 1'b0, DEV_ID},
    '{OP_PROGRAM,   18'h00003, 8'h5A, 1'b0, 8'h5A},
    '{OP_READ,      18'h00003, 8'h00, 1'b0, 8'h5A},
    '{OP_PROGRAM,   18'h00005, 8'h00, 1'b0, 8'h00}
  };
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0;
  host_req_s   req = '0;
  logic        req_ready;
  logic        rsp_valid;
  host_rsp_s   rsp;
  logic [7:0]  dev_data;
  logic [7:0]  flash_data;
  flash_pins_s pins;
  logic        viol;
  logic [7:0]  mode;
  logic [7:0]  idle;
  int          verifies;
  int          base;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign flash_data = pins.data_oe ? pins.data_out : dev_data;
  flash_host dut_u (
    .sys_clk_in    (sys_clk),
    .reset_in      (reset),
    .req_valid_in  (req_valid),
    .req_in        (req),
    .req_ready_out (req_ready),
    .rsp_valid_out (rsp_valid),
    .rsp_out       (rsp),
    .flash_data_in (flash_data),
    .pins_out      (pins)
  );
  flash_device_model #(.MFG_ID(MFG_ID), .DEV_ID(DEV_ID)) dev_u (
    .pins_in          (pins),
    .data_out         (dev_data),
    .viol_out         (viol),
    .mode_out         (mode),
    .verify_count_out (verifies)
  );
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run_op(input host_op_e op, input logic [17:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{op, addr, data};
    @(posedge sys_clk);
    while (req_ready !== 1'b1) @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (30000) begin
      @(posedge sys_clk);
      #1;
      if (rsp_valid === 1'b1) break;
    end
    check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Longest case is 25 program loops of about 940 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    idle = {pins.chip_sel_n, pins.write_n, pins.vpp_high, pins.data_oe, req_ready, 3'h0};
    check("idle", idle, 8'hC8);
    @(negedge sys_clk);
    reset = 1'b0;
    foreach (ROWS[i]) begin
      run_op(ROWS[i].op, ROWS[i].addr, ROWS[i].data);
      check("ok fail", {6'h00, rsp.ok, rsp.fail}, {6'h00, ~ROWS[i].fail, ROWS[i].fail});
      check("data", rsp.data, ROWS[i].exp);
    end
    base = verifies;
    run_op(OP_PROGRAM, 18'h00003, 8'hFF);
    check("retry fail", {7'h00, rsp.fail}, 8'h01);
    check("retries", 8'(verifies - base), 8'(MAX_PROGRAM_LOOPS));
    run_op(OP_ABORT, 18'h00000, 8'h00);
    check("abort mode", mode, CMD_SET_READ);
    run_op(OP_READ, 18'h00005, 8'h00);
    check("after abort", rsp.data, 8'h00);
    check("device rules", {7'h00, viol}, 8'h00);
    report_and_stop();
  end
endmodule

// File: bench/flash_host_monitor.sv
// Checker on the flash host controller ports
`timescale 1ns/10ps
module flash_host_monitor
  import flash_host_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic        req_valid_in,
  input wire logic        req_ready_out,
  input wire logic        rsp_valid_out,
  input wire flash_pins_s pins_out
);
  logic [9:0] gap;
  logic       wr_prev;
  // Saturates so long idle spans never wrap to a small gap
  always_ff @(posedge sys_clk_in) begin
    wr_prev <= pins_out.write_n;
    if (reset_in) gap <= 10'h3FF;
    else if (pins_out.write_n && !wr_prev) gap <= 10'h001;
    else if (gap != 10'h3FF) gap <= gap + 10'h001;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence strobe_low;
    !pins_out.write_n;
  endsequence
  sequence strobe_rise;
    $rose(pins_out.write_n);
  endsequence
  a_reset_idle:
    assert property ($fell(reset_in) |-> pins_out.chip_sel_n && pins_out.write_n
      && !pins_out.vpp_high && !pins_out.data_oe && req_ready_out) else $error("not idle");
  a_write_vpp:
    assert property (strobe_low |-> pins_out.vpp_high && !pins_out.chip_sel_n
      && pins_out.out_gate_n) else $error("write without vpp");
  a_data_held:
    assert property (strobe_low ##1 strobe_low |-> pins_out.data_oe
      && $stable(pins_out.data_out) && $stable(pins_out.addr)) else $error("data moved");
  a_rise_hold:
    assert property (strobe_rise |-> pins_out.data_oe && !pins_out.chip_sel_n)
      else $error("data released at rise");
  a_read_quiet:
    assert property (!pins_out.out_gate_n |-> !pins_out.data_oe && pins_out.write_n)
      else $error("drive during read");
  a_read_recovery:
    assert property ($fell(pins_out.out_gate_n) |-> int'(gap) >= RECOVERY_CYCLES)
      else $error("read too soon");
  a_pulse_time:
    assert property ($fell(pins_out.write_n) && pins_out.data_out == CMD_PROG_VERIFY
      |-> int'(gap) >= PROGRAM_PULSE_CYCLES) else $error("pulse cut short");
  a_ready_drop:
    assert property (req_valid_in && req_ready_out |=> !req_ready_out)
      else $error("ready stayed");
  a_rsp_pulse:
    assert property (rsp_valid_out |=> !rsp_valid_out) else $error("long rsp");
endmodule
bind flash_host flash_host_monitor mon_u (
  .sys_clk_in    (sys_clk_in),
  .reset_in      (reset_in),
  .req_valid_in  (req_valid_in),
  .req_ready_out (req_ready_out),
  .rsp_valid_out (rsp_valid_out),
  .pins_out      (pins_out)
);

// File: common/flash_host_pkg.sv
// Package: constants and carriers for the parallel flash host controller
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_READ     = 8'h00;
  localparam logic [7:0] CMD_SIGNATURE    = 8'h90;
  localparam logic [7:0] CMD_ERASE        = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY  = 8'hC0;
  localparam logic [7:0] CMD_RESET        = 8'hFF;
  localparam logic [7:0] ERASED_BYTE      = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ                 = 40;
  localparam int PROGRAM_PULSE_TIME_NS   = 10000;
  localparam int ERASE_PULSE_TIME_NS     = 9500000;
  localparam int WRITE_TO_READ_RECOVERY_NS = 6000;
  localparam int CLK_PERIOD_NS           = 1000 / CLK_MHZ;
  localparam int PROGRAM_PULSE_CYCLES    =
    (PROGRAM_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_PULSE_CYCLES      =
    (ERASE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYCLES         =
    (WRITE_TO_READ_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES           = 4;
  localparam int MAX_PROGRAM_LOOPS       = 25;
  localparam int TIMER_W                 = 20;
  localparam logic [4:0] LOOP_RESET      = 5'h00;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 20'h00000;

  // ----------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_SIGNATURE = 3'h1,
    OP_PROGRAM   = 3'h2,
    OP_ERASE     = 3'h3,
    OP_ABORT     = 3'h4
  } host_op_e;

  typedef struct packed {
    host_op_e    op;
    logic [17:0] addr;
    logic [7:0]  data;
  } host_req_s;

  typedef struct packed {
    logic       ok;
    logic       fail;
    logic [7:0] data;
  } host_rsp_s;

  // Flash pins; data has separate out and enable, input on flash_data_in
  typedef struct packed {
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        write_n;
    logic        vpp_high;
    logic [17:0] addr;
    logic [7:0]  data_out;
    logic        data_oe;
  } flash_pins_s;

endpackage

// File: hw/flash_host.sv
// Host controller that sequences a parallel flash through its pins
//
// Behaviour
// - Erase, reset repeat code twice; program sends code then address and data
// - Program and verify loop repeats at most 25 times, then fails
// - Before erase, every byte is programmed to zero
// - Host waits 6 us after write strobe before any read
// - Set-read code precedes array reads
// - Erase-verify code written with address; byte read back
`timescale 1ns/10ps
module flash_host
  import flash_host_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        req_valid_in,
  input  wire host_req_s   req_in,
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output host_rsp_s        rsp_out,
  input  wire logic [7:0]  flash_data_in,
  output flash_pins_s      pins_out
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    S_IDLE     = 11'b000_0000_0001,
    S_WR_SETUP = 11'b000_0000_0010,
    S_WR_LOW   = 11'b000_0000_0100,
    S_WR_HOLD  = 11'b000_0000_1000,
    S_WAIT     = 11'b000_0001_0000,
    S_RD_LOW   = 11'b000_0010_0000,
    S_RD_TAKE  = 11'b000_0100_0000,
    S_NEXT     = 11'b000_1000_0000,
    S_DONE     = 11'b001_0000_0000,
    S_RD_SETUP = 11'b010_0000_0000,
    S_SPARE    = 11'b100_0000_0000
  } state_e;

  state_e             state;
  host_req_s          req;
  logic [2:0]         step;
  logic [TIMER_W-1:0] timer;
  logic [4:0]         loops;
  logic [17:0]        sweep;
  logic               erasing;
  logic [7:0]         data_sync1;
  logic [7:0]         data_sync2;
  logic [7:0]         cmd_byte;
  logic               cmd_has_addr;
  logic [TIMER_W-1:0] after_wait;

  // Longest of pulse and recovery, as a cycle count
  function automatic logic [TIMER_W-1:0] wait_for(input int cyc);
    wait_for = TIMER_W'(cyc > RECOVERY_CYCLES ? cyc : RECOVERY_CYCLES);
  endfunction

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    data_sync1 <= flash_data_in;
    data_sync2 <= data_sync1;
  end

  // ----------------------------------------------------------------
  // Write byte for current op and step
  // ----------------------------------------------------------------
  always_comb begin
    cmd_byte     = CMD_SET_READ;
    cmd_has_addr = 1'b0;
    after_wait   = wait_for(0);
    case (req.op)
      OP_SIGNATURE: cmd_byte = CMD_SIGNATURE;
      OP_ABORT:     cmd_byte = CMD_RESET;
      OP_PROGRAM: begin
        if (step == 3'd0) begin
          cmd_byte = CMD_PROGRAM;
        end else if (step == 3'd1) begin
          cmd_byte     = erasing ? 8'h00 : req.data;
          cmd_has_addr = 1'b1;
          after_wait   = wait_for(PROGRAM_PULSE_CYCLES);
        end else begin
          cmd_byte = CMD_PROG_VERIFY;
        end
      end
      OP_ERASE: begin
        if (!erasing || step == 3'd2) begin
          cmd_byte     = CMD_ERASE_VERIFY;
          cmd_has_addr = 1'b1;
        end else begin
          cmd_byte = CMD_ERASE;
          if (step == 3'd1) begin
            after_wait = wait_for(ERASE_PULSE_CYCLES);
          end
        end
      end
      default: cmd_byte = CMD_SET_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state         <= S_IDLE;
      req           <= '0;
      step          <= 3'd0;
      timer         <= TIMER_RESET;
      loops         <= LOOP_RESET;
      sweep         <= '0;
      erasing       <= 1'b0;
      req_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_out       <= '0;
      pins_out      <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1,
                         vpp_high: 1'b0, addr: '0, data_out: '0, data_oe: 1'b0};
    end else begin
      rsp_valid_out <= 1'b0;
      timer         <= (timer != TIMER_RESET) ? timer - 1'b1 : timer;
      case (state)
        S_IDLE: begin
          pins_out.chip_sel_n <= 1'b1;
          pins_out.out_gate_n <= 1'b1;
          pins_out.data_oe    <= 1'b0;
          if (req_valid_in && req_ready_out) begin
            // Erase opens with the zero sweep, run as program steps
            req                <= '{op: (req_in.op == OP_ERASE) ? OP_PROGRAM : req_in.op,
                                    addr: req_in.addr, data: req_in.data};
            req_ready_out      <= 1'b0;
            step               <= 3'd0;
            loops              <= LOOP_RESET;
            sweep              <= '0;
            erasing            <= (req_in.op == OP_ERASE);
            pins_out.vpp_high  <= 1'b1;
            timer              <= TIMER_W'(STROBE_CYCLES);
            state              <= S_WR_SETUP;
          end
        end
        S_WR_SETUP: begin
          // Output gate high before driving data avoids bus fight
          pins_out.chip_sel_n <= 1'b0;
          pins_out.out_gate_n <= 1'b1;
          pins_out.data_out   <= cmd_byte;
          pins_out.data_oe    <= 1'b1;
          pins_out.addr       <= cmd_has_addr ? (erasing ? sweep : req.addr)
                                              : '0;
          if (timer == TIMER_RESET) begin
            pins_out.write_n <= 1'b0;
            timer            <= TIMER_W'(STROBE_CYCLES);
            state            <= S_WR_LOW;
          end
        end
        S_WR_LOW: begin
          if (timer == TIMER_RESET) begin
            pins_out.write_n <= 1'b1;
            timer            <= TIMER_W'(STROBE_CYCLES);
            state            <= S_WR_HOLD;
          end
        end
        S_WR_HOLD: begin
          if (timer == TIMER_RESET) begin
            pins_out.data_oe <= 1'b0;
            timer            <= after_wait;
            state            <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (timer == TIMER_RESET) begin
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          step  <= step + 3'd1;
          timer <= TIMER_W'(STROBE_CYCLES);
          state <= S_WR_SETUP;
          case (req.op)
            OP_ABORT: if (step == 3'd1) state <= S_DONE;
            OP_READ, OP_SIGNATURE: begin
              pins_out.addr <= (req.op == OP_SIGNATURE) ? {17'h0, req.addr[0]}
                                                        : req.addr;
              state <= S_RD_SETUP;
            end
            OP_PROGRAM: if (step == 3'd2) state <= S_RD_SETUP;
            OP_ERASE: if (!erasing || step == 3'd2) state <= S_RD_SETUP;
            default: state <= S_DONE;
          endcase
        end
        S_RD_SETUP: begin
          pins_out.data_oe    <= 1'b0;
          pins_out.out_gate_n <= 1'b0;
          timer               <= TIMER_W'(STROBE_CYCLES);
          state               <= S_RD_LOW;
        end
        S_RD_LOW: begin
          if (timer == TIMER_RESET) begin
            state <= S_RD_TAKE;
          end
        end
        S_RD_TAKE: begin
          pins_out.out_gate_n <= 1'b1;
          rsp_out.data        <= data_sync2;
          timer               <= TIMER_W'(STROBE_CYCLES);
          state               <= S_DONE;
          rsp_out.ok          <= 1'b1;
          rsp_out.fail        <= 1'b0;
          if (req.op == OP_PROGRAM) begin
            if (data_sync2 != (erasing ? 8'h00 : req.data)) begin
              if (loops == 5'(MAX_PROGRAM_LOOPS - 1)) begin
                rsp_out.ok   <= 1'b0;
                rsp_out.fail <= 1'b1;
              end else begin
                loops <= loops + 5'd1;
                step  <= 3'd0;
                state <= S_WR_SETUP;
              end
            end else if (erasing) begin
              // Zero pass next byte, then start erasing
              loops <= LOOP_RESET;
              step  <= 3'd0;
              state <= S_WR_SETUP;
              if (sweep == '1) begin
                sweep   <= '0;
                req.op  <= OP_ERASE;
              end else begin
                sweep <= sweep + 18'd1;
              end
            end
          end else if (req.op == OP_ERASE) begin
            step  <= 3'd0;
            state <= S_WR_SETUP;
            if (!erasing) begin
              // Sweep just verified zero; erase next
              erasing <= 1'b1;
            end else if (data_sync2 != ERASED_BYTE) begin
              if (loops == 5'(MAX_PROGRAM_LOOPS - 1)) begin
                rsp_out.ok   <= 1'b0;
                rsp_out.fail <= 1'b1;
                state        <= S_DONE;
              end else begin
                loops <= loops + 5'd1;
              end
            end else if (sweep == '1) begin
              state <= S_DONE;
            end else begin
              sweep <= sweep + 18'd1;
              step  <= 3'd2;
            end
          end
        end
        S_DONE: begin
          if (timer == TIMER_RESET) begin
            pins_out.vpp_high   <= 1'b0;
            pins_out.chip_sel_n <= 1'b1;
            rsp_valid_out       <= 1'b1;
            req_ready_out       <= 1'b1;
            state               <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule
